// ==== common/tkc_pkg.sv ====
// package for the touch key module control block: offsets, fields, resets
// How it works
// - ten-bit capacitor setting per module, resets zero
// - auto mode reloads capacitor from data memory
// - doubling bit doubles key oscillator frequency
// - filter enable bit, one enables filter
// - hop select bit picks field or hardware
// - three-bit field selects eight hopping steps
// - slot clock from reference or sysclk/4
// - busy fall clears reference oscillator enable
// - busy fall clears key enable; auto start sets
// - auto start sets module zero reference enable
// - other modules set only with keys, own clocks
// - four key enables assign pins as keys
// - slot fields pick key per auto slot
// - manual mode uses slot zero field only
// - mode bit: zero auto, one manual
// - busy sets on start, clears at scan end
// - shared counter select uses module zero counter
package tkc_pkg;
    localparam int TKC_NMOD = 7;
    localparam int TKC_NSLOT = 4;
    // per-module block of five words, module n at n*MOD_STRIDE
    localparam logic [7:0] TKC_MOD_STRIDE = 8'h20;
    localparam logic [4:0] TKC_OFF_CAP_HIGH = 5'h00;
    localparam logic [4:0] TKC_OFF_CAP_LOW = 5'h04;
    localparam logic [4:0] TKC_OFF_FREQ = 5'h08;
    localparam logic [4:0] TKC_OFF_OSCKEY = 5'h0C;
    localparam logic [4:0] TKC_OFF_SLOTKEY = 5'h10;
    // global control and status word
    localparam logic [7:0] TKC_OFF_GLOBAL = 8'hE0;
    // capacitor memory window: word per (module,slot) entry
    localparam logic [7:0] TKC_OFF_CAPMEM = 8'h00;
    localparam logic [11:0] TKC_CAPMEM_BASE = 12'h100;
    // global word fields
    localparam int TKC_G_START = 0;
    localparam int TKC_G_MODE = 1;
    localparam int TKC_G_SHARED = 2;
    localparam int TKC_G_BUSY = 8;
    // freq control fields
    localparam int TKC_F_DOUBLE = 5;
    localparam int TKC_F_FILTER = 4;
    localparam int TKC_F_HOPSEL = 3;
    // osc/key enable fields
    localparam int TKC_K_SLOTCLK = 7;
    localparam int TKC_K_REFEN = 5;
    localparam int TKC_K_KEYEN = 4;
    localparam logic [7:0] TKC_FREQ_MASK = 8'h3F;
    localparam logic [7:0] TKC_OSCKEY_MASK = 8'hBF;
    localparam logic [7:0] TKC_CAPH_MASK = 8'h03;
    localparam logic [7:0] TKC_SLOTKEY_RESET = 8'hE4;
    localparam logic [9:0] TKC_CAP_RESET = 10'h000;
    localparam logic [7:0] TKC_CTRL_RESET = 8'h00;
    // sysclk/4 slot clock divider and default slot length
    localparam logic [1:0] TKC_DIV4_LAST = 2'h3;
    localparam logic [7:0] TKC_SLOT_LEN_RESET = 8'hFF;
    localparam logic [1:0] TKC_OKAY = 2'h0;
    localparam logic [1:0] TKC_SLVERR = 2'h2;
endpackage

// ==== rtl/tkc_slot_counter.sv ====
// slot counter for one module: counts its selected clock ticks
`timescale 1ns/1ps
module tkc_slot_counter
    import tkc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic restart,
    input wire logic clk_sel,
    input wire logic ref_tick,
    input wire logic div4_tick,
    input wire logic [7:0] slot_len,
    output logic overflow
);
    typedef struct packed {
        logic [7:0] cnt;
        logic ovf;
    } tkc_cnt_s;
    tkc_cnt_s s_q, s_d;
    logic tick;

    always_comb begin
        tick = clk_sel ? div4_tick : ref_tick;
        s_d = s_q;
        s_d.ovf = 1'b0;
        if (restart) begin
            s_d.cnt = 8'h00;
        end else if (run && tick) begin
            if (s_q.cnt == slot_len) begin
                s_d.cnt = 8'h00;
                s_d.ovf = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign overflow = s_q.ovf;
endmodule

// ==== rtl/tkc_top.sv ====
// touch key module control: registers, scan sequencing, oscillator enables
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module tkc_top
    import tkc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [6:0] ref_osc_tick,
    output logic [6:0] ref_osc_run,
    output logic [6:0] key_osc_run,
    output logic [69:0] ref_cap,
    output logic [6:0] freq_double_en,
    output logic [6:0] filter_en,
    output logic [6:0] hop_ctrl_sel,
    output logic [20:0] hop_freq_sel,
    output logic [27:0] touch_key_pin_en,
    output logic [13:0] scan_key_sel,
    output logic [6:0] slot_clk_sel,
    output logic [1:0] scan_slot,
    output logic scan_busy
);
    typedef enum logic [1:0] {
        TKC_IDLE, TKC_SCAN
    } tkc_state_e;

    typedef struct packed {
        logic [TKC_NMOD-1:0][9:0] cap;
        logic [TKC_NMOD-1:0][7:0] freq;
        logic [TKC_NMOD-1:0][7:0] osckey;
        logic [TKC_NMOD-1:0][7:0] slotkey;
        logic [TKC_NMOD*TKC_NSLOT-1:0][9:0] capmem;
        logic start;
        logic mode;
        logic shared;
        logic [7:0] slot_len;
        tkc_state_e state;
        logic [1:0] slot;
        logic [1:0] div4;
        logic [TKC_NMOD-1:0] ovf_seen;
        logic aw_got;
        logic [11:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tkc_state_s;

    tkc_state_s s_q, s_d;
    logic [TKC_NMOD-1:0] ovf;
    logic [TKC_NMOD-1:0] cnt_clksel;
    logic cnt_restart;
    logic div4_tick;
    logic slot_end;

    assign div4_tick = (s_q.div4 == TKC_DIV4_LAST);
    // restart counters at the start edge and between auto slots
    assign cnt_restart = (s_q.state == TKC_IDLE) || slot_end;

    genvar g;
    generate
        for (g = 0; g < TKC_NMOD; g++) begin : g_cnt
            assign cnt_clksel[g] = s_q.osckey[g][TKC_K_SLOTCLK];
            tkc_slot_counter u_cnt (
                .aclk(aclk),
                .aresetn(aresetn),
                .run(s_q.state == TKC_SCAN),
                .restart(cnt_restart),
                .clk_sel(cnt_clksel[g]),
                .ref_tick(ref_osc_tick[g]),
                .div4_tick(div4_tick),
                .slot_len(s_q.slot_len),
                .overflow(ovf[g])
            );
        end
    endgenerate

    // with the shared select every module follows module 0's counter
    always_comb begin
        slot_end = ovf[0];
        if (!s_q.shared) begin
            slot_end = 1'b1;
            for (int m = 0; m < TKC_NMOD; m++) begin
                // a module that overflowed early waits for the slower ones
                if (s_q.osckey[m][TKC_K_REFEN] && !ovf[m] &&
                        !s_q.ovf_seen[m]) begin
                    slot_end = 1'b0;
                end
            end
            if (s_q.osckey[0][TKC_K_REFEN] == 1'b0) begin
                slot_end = ovf[0];
            end
        end
    end

    // ======================================================
    // register access, scan sequencing
    // ======================================================
    always_comb begin
        logic [7:0] off;
        logic [2:0] mi;
        logic [4:0] ri;
        logic [4:0] ci;
        logic [7:0] wb;
        logic [7:0] rb;
        logic rise;
        logic done;
        logic [1:0] nslot;
        off = 8'h00;
        mi = 3'h0;
        ri = 5'h00;
        ci = 5'h00;
        wb = 8'h00;
        rb = 8'h00;
        rise = 1'b0;
        done = 1'b0;
        nslot = 2'h0;
        s_d = s_q;
        s_d.div4 = s_q.div4 + 2'h1;
        // own counters rarely overflow in one cycle, so remember who is done
        if (s_q.state == TKC_IDLE || slot_end) begin
            s_d.ovf_seen = '0;
        end else begin
            s_d.ovf_seen = s_q.ovf_seen | ovf;
        end

        // write side: take address and data in either order
        if (s_axi_awvalid && !s_q.aw_got) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_got) begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = TKC_OKAY;
            off = s_q.awaddr[7:0];
            mi = off[7:5];
            ri = off[4:0];
            // byte registers sit in lane 0; its strobe gates them all
            wb = s_q.wstrb[0] ? s_q.wdata[7:0] : 8'h00;
            if (!s_q.wstrb[0]) begin
                s_d.bresp = TKC_OKAY;
            end else if (s_q.awaddr[11:8] == TKC_CAPMEM_BASE[11:8]) begin
                ci = off[6:2];
                if (off[7] || ci >= 5'(TKC_NMOD*TKC_NSLOT)) begin
                    s_d.bresp = TKC_SLVERR;
                end else begin
                    s_d.capmem[ci] = s_q.wdata[9:0];
                end
            end else if (s_q.awaddr[11:8] != 4'h0) begin
                s_d.bresp = TKC_SLVERR;
            end else if (off == TKC_OFF_GLOBAL) begin
                s_d.start = wb[TKC_G_START];
                s_d.mode = wb[TKC_G_MODE];
                s_d.shared = wb[TKC_G_SHARED];
                if (s_q.wstrb[2]) begin
                    s_d.slot_len = s_q.wdata[23:16];
                end
            end else if (mi >= 3'(TKC_NMOD)) begin
                s_d.bresp = TKC_SLVERR;
            end else begin
                case (ri)
                    TKC_OFF_CAP_HIGH: s_d.cap[mi][9:8] = wb[1:0];
                    TKC_OFF_CAP_LOW: s_d.cap[mi][7:0] = wb;
                    TKC_OFF_FREQ: s_d.freq[mi] = wb & TKC_FREQ_MASK;
                    TKC_OFF_OSCKEY: s_d.osckey[mi] = wb & TKC_OSCKEY_MASK;
                    TKC_OFF_SLOTKEY: s_d.slotkey[mi] = wb;
                    default: s_d.bresp = TKC_SLVERR;
                endcase
            end
        end

        // read side: one read in flight, answer the cycle after
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = TKC_OKAY;
            s_d.rdata = 32'h0000_0000;
            off = s_axi_araddr[7:0];
            mi = off[7:5];
            ri = off[4:0];
            if (s_axi_araddr[11:8] == TKC_CAPMEM_BASE[11:8]) begin
                ci = off[6:2];
                if (off[7] || ci >= 5'(TKC_NMOD*TKC_NSLOT)) begin
                    s_d.rresp = TKC_SLVERR;
                end else begin
                    s_d.rdata = {22'h0, s_q.capmem[ci]};
                end
            end else if (s_axi_araddr[11:8] != 4'h0) begin
                s_d.rresp = TKC_SLVERR;
            end else if (off == TKC_OFF_GLOBAL) begin
                // slot shows at [13:12] so it does not overlay the length
                s_d.rdata = {8'h00, s_q.slot_len, 2'h0, s_q.slot,
                             3'h0, (s_q.state == TKC_SCAN),
                             5'h00, s_q.shared, s_q.mode, s_q.start};
            end else if (mi >= 3'(TKC_NMOD)) begin
                s_d.rresp = TKC_SLVERR;
            end else begin
                case (ri)
                    TKC_OFF_CAP_HIGH: rb = {6'h00, s_q.cap[mi][9:8]};
                    TKC_OFF_CAP_LOW: rb = s_q.cap[mi][7:0];
                    TKC_OFF_FREQ: rb = s_q.freq[mi];
                    TKC_OFF_OSCKEY: rb = s_q.osckey[mi];
                    TKC_OFF_SLOTKEY: rb = s_q.slotkey[mi];
                    default: s_d.rresp = TKC_SLVERR;
                endcase
                s_d.rdata = {24'h0, rb};
            end
        end

        // scan sequencing; start edge only seen while idle
        rise = s_d.start && !s_q.start;
        case (s_q.state)
            TKC_IDLE: begin
                if (rise) begin
                    s_d.state = TKC_SCAN;
                    s_d.slot = 2'h0;
                    if (!s_q.mode) begin
                        for (int m = 0; m < TKC_NMOD; m++) begin
                            s_d.osckey[m][TKC_K_KEYEN] = 1'b1;
                            if (m == 0) begin
                                s_d.osckey[m][TKC_K_REFEN] = 1'b1;
                            end else if (s_d.osckey[m][3:0] != 4'h0 &&
                                    !s_d.osckey[m][TKC_K_SLOTCLK] &&
                                    !s_d.shared) begin
                                s_d.osckey[m][TKC_K_REFEN] = 1'b1;
                            end
                            // slot 0 capacitor comes from memory first
                            s_d.cap[m] = s_q.capmem[m*TKC_NSLOT];
                        end
                    end
                end
            end
            TKC_SCAN: begin
                if (slot_end) begin
                    if (s_q.mode) begin
                        done = 1'b1;
                    end else begin
                        nslot = s_q.slot + 2'h1;
                        // slot 3 wraps the reload back to slot 0
                        for (int m = 0; m < TKC_NMOD; m++) begin
                            s_d.cap[m] =
                                s_q.capmem[m*TKC_NSLOT + int'(nslot)];
                        end
                        s_d.slot = nslot;
                        done = (s_q.slot == 2'h3);
                    end
                end
                // busy falling clears every reference and key oscillator enable on the same edge; pin and slot clock bits stay
                if (done) begin
                    s_d.state = TKC_IDLE;
                    for (int m = 0; m < TKC_NMOD; m++) begin
                        s_d.osckey[m][TKC_K_REFEN] = 1'b0;
                        s_d.osckey[m][TKC_K_KEYEN] = 1'b0;
                    end
                end
            end
            default: s_d.state = TKC_IDLE;
        endcase
    end

    // reset gives key sequence one to four and the longest slot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.slot_len <= TKC_SLOT_LEN_RESET;
            s_q.state <= TKC_IDLE;
            for (int m = 0; m < TKC_NMOD; m++) begin
                s_q.cap[m] <= TKC_CAP_RESET;
                s_q.freq[m] <= TKC_CTRL_RESET;
                s_q.osckey[m] <= TKC_CTRL_RESET;
                s_q.slotkey[m] <= TKC_SLOTKEY_RESET;
            end
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================
    // outputs toward the sense oscillators and pins
    // ======================================================
    always_comb begin
        for (int m = 0; m < TKC_NMOD; m++) begin
            ref_osc_run[m] = s_q.osckey[m][TKC_K_REFEN];
            key_osc_run[m] = s_q.osckey[m][TKC_K_KEYEN];
            ref_cap[m*10 +: 10] = s_q.cap[m];
            freq_double_en[m] = s_q.freq[m][TKC_F_DOUBLE];
            filter_en[m] = s_q.freq[m][TKC_F_FILTER];
            hop_ctrl_sel[m] = s_q.freq[m][TKC_F_HOPSEL];
            // field is don't-care when hardware hopping is selected
            hop_freq_sel[m*3 +: 3] = s_q.freq[m][TKC_F_HOPSEL] ?
                3'h0 : s_q.freq[m][2:0];
            touch_key_pin_en[m*4 +: 4] = s_q.osckey[m][3:0];
            slot_clk_sel[m] = s_q.osckey[m][TKC_K_SLOTCLK];
            // manual mode muxes by slot 0 field only
            scan_key_sel[m*2 +: 2] = s_q.mode ? s_q.slotkey[m][1:0] :
                s_q.slotkey[m][2*s_q.slot +: 2];
        end
    end

    assign scan_slot = s_q.slot;
    assign scan_busy = (s_q.state == TKC_SCAN);
    // address and data each hold one entry until the write is done and its response raised
    assign s_axi_awready = !s_q.aw_got;
    assign s_axi_wready = !s_q.w_got;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
endmodule

// ==== tb/tkc_pad_model.sv ====
// pad model: reference oscillator ticks while the block enables them
`timescale 1ns/1ps
module tkc_pad_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [6:0] ref_osc_run,
    output logic [6:0] ref_osc_tick
);
    // one shared divide-by-three phase; a stopped oscillator gives no ticks
    logic [1:0] ph_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || ph_q == 2'h2) begin
            ph_q <= 2'h0;
        end else begin
            ph_q <= ph_q + 2'h1;
        end
    end
    assign ref_osc_tick = (ph_q == 2'h0) ? ref_osc_run : 7'h00;
endmodule

// ==== tb/tkc_top_asserts.sv ====
// checker: bus handshakes, scan sequencing and oscillator enable relations
`timescale 1ns/1ps
module tkc_top_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [6:0] ref_osc_run,
    input wire logic [6:0] key_osc_run,
    input wire logic [69:0] ref_cap,
    input wire logic [6:0] hop_ctrl_sel,
    input wire logic [20:0] hop_freq_sel,
    input wire logic [13:0] scan_key_sel,
    input wire logic [1:0] scan_slot,
    input wire logic scan_busy
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // register bus
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_answer;
        (!s_axi_awready && !s_axi_wready) ##1 s_axi_bvalid;
    endsequence
    a_write_walk: assert property (s_wr_taken |=> s_wr_answer)
        else $error("write answer out of step");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read answer late");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken while data pending");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");

    // ==========================================================
    // scan control
    a_hop_forced: assert property (
        hop_ctrl_sel[6] |-> hop_freq_sel[20:18] == 3'h0)
        else $error("hop code not ignored");
    a_slot_step: assert property (
        scan_busy && $past(scan_busy) && $changed(scan_slot)
        |-> scan_slot == $past(scan_slot) + 2'h1)
        else $error("slot skipped");
    a_busy_fall_osc: assert property ($fell(scan_busy)
        |-> ##[0:1] (ref_osc_run == 7'h00 && key_osc_run == 7'h00))
        else $error("oscillators left on after scan");
    a_reset_clear: assert property ($rose(aresetn)
        |-> !scan_busy && ref_cap == 70'h0 && scan_key_sel == 14'h0000)
        else $error("reset state wrong");
endmodule

bind tkc_top tkc_top_asserts u_tkc_chk (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ref_osc_run(ref_osc_run), .key_osc_run(key_osc_run), .ref_cap(ref_cap),
    .hop_ctrl_sel(hop_ctrl_sel), .hop_freq_sel(hop_freq_sel),
    .scan_key_sel(scan_key_sel), .scan_slot(scan_slot), .scan_busy(scan_busy)
);

// ==== tb/tkc_top_tb_top.sv ====
// self-checking bench: register access, auto scan and manual scan
`timescale 1ns/1ps
module tkc_top_tb_top
    import tkc_pkg::*;
;
    localparam logic [11:0] GLB = {4'h0, TKC_OFF_GLOBAL};
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, q;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, busy;
    logic [1:0] bresp, rresp, r, slot;
    logic [31:0] rdata;
    logic [6:0] tick, ref_run, key_run, dbl, fil, hopc, tss;
    logic [69:0] ref_cap;
    logic [20:0] hopf;
    logic [27:0] pin;
    logic [13:0] ksel;
    logic [7:0] msk [5] = '{TKC_CAPH_MASK, 8'hFF, TKC_FREQ_MASK,
        TKC_OSCKEY_MASK, 8'hFF};
    int n_errors = 0, n_tests = 0;

    always #5 aclk = ~aclk;

    tkc_top DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ref_osc_tick(tick), .ref_osc_run(ref_run),
        .key_osc_run(key_run), .ref_cap(ref_cap), .freq_double_en(dbl),
        .filter_en(fil), .hop_ctrl_sel(hopc), .hop_freq_sel(hopf),
        .touch_key_pin_en(pin), .scan_key_sel(ksel), .slot_clk_sel(tss),
        .scan_slot(slot), .scan_busy(busy)
    );
    tkc_pad_model PAD (
        .aclk(aclk), .aresetn(aresetn), .ref_osc_run(ref_run),
        .ref_osc_tick(tick)
    );

    // ==========================================================
    // helpers
    task automatic stop_test();
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask

    // sampling at the falling edge sees exactly what the next rise takes
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        logic ta, tw, tar, tr;
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= w;
        wvalid <= w;
        bready <= w;
        arvalid <= !w;
        rready <= !w;
        forever begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tar = arvalid && arready;
            tr = w ? bvalid : rvalid;
            q = rdata;
            r = w ? bresp : rresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tar) arvalid <= 1'b0;
            if (tr) break;
        end
        bready <= 1'b0;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
        chk(32'(r), 32'(TKC_OKAY));
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    function automatic logic [11:0] ad(input int m, input int o);
        return 12'(m * 32 + o * 4);
    endfunction

    task automatic wt(input logic b, input logic [1:0] s);
        logic c;
        c = 1'b0;
        for (int k = 0; k < 400 && !c; k++) begin
            @(negedge aclk);
            c = busy === b && (!b || slot === s);
        end
        chk(32'(c), 32'h1);
    endtask

    // ==========================================================
    // tests
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (int m = 0; m < 7; m += 6) begin
            for (int o = 0; o < 4; o++) rd(ad(m, o), 32'h0);
            rd(ad(m, 4), 32'(TKC_SLOTKEY_RESET));
        end
        for (int o = 0; o < 5; o++) wr(ad(6, o), 32'hFF);
        for (int o = 0; o < 5; o++) rd(ad(6, o), 32'(msk[o]));
        @(negedge aclk);
        chk(32'(ref_cap[69:60]), 32'h3FF);
        chk(32'({dbl[6], fil[6], hopc[6]}), 32'h7);
        chk(32'(hopf[20:18]), 32'h0);
        chk(32'({tss[6], ref_run[6], key_run[6]}), 32'h7);
        chk(32'(pin[27:24]), 32'hF);
        chk(32'(ksel[13:12]), 32'h3);
        for (int c = 0; c < 8; c++) begin
            wr(ad(6, 2), 32'(c));
            @(negedge aclk);
            chk(32'(hopf[20:18]), 32'(c));
        end
        chk(32'({dbl[6], hopc[6]}), 32'h0);
        wr(ad(6, 3), 32'h0F);
        acc(1'b0, 12'h014, 32'h0);
        chk(32'(r), 32'(TKC_SLVERR));
        acc(1'b1, 12'hF00, 32'h5A);
        chk(32'(r), 32'(TKC_SLVERR));
        // auto scan: module 0 on the divided clock, module 1 has keys only
        for (int s = 0; s < 4; s++) begin
            wr(TKC_CAPMEM_BASE + 12'(s * 4), 32'h2A0 + 32'(s));
        end
        wr(ad(0, 4), 32'h1B);
        wr(ad(0, 3), 32'h80);
        wr(ad(1, 3), 32'h0F);
        wr(GLB, 32'h0002_0004);
        wr(GLB, 32'h0002_0005);
        for (int s = 0; s < 4; s++) begin
            wt(1'b1, 2'(s));
            repeat (3) @(negedge aclk);
            chk(32'(ref_cap[9:0]), 32'h2A0 + 32'(s));
            chk(32'(ksel[1:0]), 32'(3 - s));
            chk(32'({ref_run[1:0], key_run[0]}), 32'h3);
        end
        wt(1'b0, 2'h0);
        chk(32'({ref_run, key_run}), 32'h0);
        rd(ad(0, 3), 32'h80);
        rd(ad(1, 3), 32'h0F);
        // manual scan: software enables both oscillators first
        wr(GLB, 32'h0002_0006);
        wr(ad(0, 3), 32'hB1);
        wr(GLB, 32'h0002_0007);
        wt(1'b1, 2'h0);
        chk(32'({ksel[1:0], slot, key_run[0]}), 32'h19);
        acc(1'b0, GLB, 32'h0);
        chk(32'(q[8]), 32'h1);
        wt(1'b0, 2'h0);
        chk(32'({ref_run, key_run}), 32'h0);
        // auto scan on own counters: modules 1 and 6 join on their keys
        wr(GLB, 32'h0002_0000);
        wr(GLB, 32'h0002_0001);
        wt(1'b1, 2'h0);
        chk(32'(ref_run), 32'h43);
        wt(1'b0, 2'h0);
        chk(32'({ref_run, key_run}), 32'h0);
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        stop_test();
    end
endmodule
